// ---- src/usmic_ctrl.sv ----
// frame-format, line-mode, smart-card reject and interrupt mask control with APB access
`default_nettype none
module usmic_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic sck_pin_out,
  output logic sck_pin_oe,
  // core transceiver side
  input wire logic core_txd,
  input wire logic core_sck,
  input wire logic sample_tick,
  input wire logic char_done,
  input wire logic parity_err,
  input wire logic [31:0] status_in,
  output logic core_rxd,
  output logic reject_signal,
  output logic [8:0] tx_char,
  output logic tx_char_write,
  output usmic_pkg::usmic_cfg_t cfg,
  // interrupt
  output logic irq
);
  import usmic_pkg::*;

  usmic_state_t st;
  usmic_state_t next_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic majority3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    if (a == USMIC_CMD_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_MODE_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_IRQ_ENABLE_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_IRQ_DISABLE_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_IRQ_VIEW_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_STATUS_OFFS) begin
      return 1'b1;
    end else if (a == USMIC_TX_HOLD_OFFS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // ------------------------------------------------------------
  // decoded views of the current state
  // ------------------------------------------------------------
  logic setup_phase;
  logic access_fire;
  logic wr_fire;
  logic rd_setup;
  logic [31:0] status_view;
  logic rx_line;
  usmic_loop_t loop_mode;
  logic [3:0] opmode;
  logic smart_card;
  logic iter_reset_now;
  logic limit_hit;
  logic [2:0] max_iter;

  assign setup_phase = psel & ~penable;
  assign access_fire = psel & penable & st.pready;
  assign wr_fire = access_fire & pwrite;
  assign rd_setup = setup_phase & ~pwrite;
  assign loop_mode = usmic_loop_t'(st.mode[USMIC_F_LOOP +: 2]);
  assign opmode = st.mode[USMIC_F_OPMODE +: 4];
  assign smart_card = (opmode == USMIC_OPMODE_T0) | (opmode == USMIC_OPMODE_T1);
  assign max_iter = st.mode[USMIC_F_MAXIT +: 3];
  // reset-iterations command is ignored outside smart-card operation
  assign iter_reset_now = wr_fire & (paddr == USMIC_CMD_OFFS) & pwdata[USMIC_B_RST_ITER] &
                          smart_card;
  // the set event of the repeat-limit flag, shared by the flag logic and its check
  assign limit_hit = char_done & parity_err & ~st.mode[USMIC_F_INHIBIT] & st.mode[USMIC_F_LIMIT] &
                     (opmode == USMIC_OPMODE_T0) & (st.err_count >= max_iter);
  // the block owns the repeat-limit flag; the core supplies the rest
  assign status_view = {status_in[31:USMIC_B_ITER_FLAG + 1], st.iter_flag,
                        status_in[USMIC_B_ITER_FLAG - 1:0]};
  // filter votes over sixteenth-bit samples, else the synchronised line
  assign rx_line = st.mode[USMIC_F_FILTER] ? majority3(st.filt_hist) : st.rx_clean;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.reject_signal = 1'b0;
    next_st.tx_char_write = 1'b0;

    // three-stage input sync; a level only counts once stages two and three agree
    next_st.rx_sync = {st.rx_sync[1:0], rxd_pin};
    if (st.rx_sync[1] == st.rx_sync[2]) begin
      next_st.rx_clean = st.rx_sync[2];
    end
    if (sample_tick) begin
      next_st.filt_hist = {st.filt_hist[1:0], st.rx_clean};
    end

    // line routing
    case (loop_mode)
      USMIC_LOOP_ECHO: begin
        next_st.txd = rx_line;
        next_st.core_rxd = rx_line;
      end
      USMIC_LOOP_LOCAL: begin
        next_st.txd = 1'b1;
        next_st.core_rxd = core_txd;
      end
      USMIC_LOOP_REMOTE: begin
        // receiver sees an idle line while the pins are strapped together
        next_st.txd = rx_line;
        next_st.core_rxd = 1'b1;
      end
      default: begin
        next_st.txd = core_txd;
        next_st.core_rxd = rx_line;
      end
    endcase

    // clock pin: never fight an external clock on the same pin
    next_st.sck_oe = st.mode[USMIC_F_CLKDRV] &
                     (st.mode[USMIC_F_CLKSEL +: 2] != USMIC_CLKSEL_PIN);
    next_st.sck_out = core_sck;

    // smart-card reject handling
    if (char_done) begin
      if (parity_err) begin
        if (st.mode[USMIC_F_INHIBIT]) begin
          next_st.reject_signal = 1'b0;
        end else if (st.mode[USMIC_F_LIMIT] && opmode == USMIC_OPMODE_T0) begin
          if (st.err_count < max_iter) begin
            next_st.reject_signal = 1'b1;
            next_st.err_count = st.err_count + 3'h1;
          end else begin
            next_st.iter_flag = 1'b1;
          end
        end else begin
          next_st.reject_signal = 1'b1;
        end
      end else begin
        // a clean character breaks the run of successive errors
        next_st.err_count = 3'h0;
      end
    end
    if (iter_reset_now) begin
      next_st.err_count = 3'h0;
      // a limit hit in the same cycle still wins
      if (!limit_hit) begin
        next_st.iter_flag = 1'b0;
      end
    end

    // register writes take effect at the completing access edge
    if (wr_fire) begin
      if (paddr == USMIC_MODE_OFFS) begin
        next_st.mode = pwdata;
      end else if (paddr == USMIC_IRQ_ENABLE_OFFS) begin
        next_st.irq_mask = st.irq_mask | (pwdata & USMIC_IRQ_VALID);
      end else if (paddr == USMIC_IRQ_DISABLE_OFFS) begin
        next_st.irq_mask = st.irq_mask & ~(pwdata & USMIC_IRQ_VALID);
      end else if (paddr == USMIC_TX_HOLD_OFFS) begin
        next_st.tx_char = pwdata[8:0];
        next_st.tx_char_write = 1'b1;
        next_st.tx_sync_latch = pwdata[USMIC_B_TX_SYNC];
      end
    end

    // registered configuration outputs follow the new mode word
    case (next_st.mode[USMIC_F_STOP +: 2])
      2'h0: begin
        next_st.cfg.stop_halves = 3'h2;
        next_st.cfg.stop_reserved = 1'b0;
      end
      2'h1: begin
        // 1.5 stop bits exists only without the synchronous clock
        next_st.cfg.stop_halves = next_st.mode[USMIC_F_SYNC] ? 3'h2 : 3'h3;
        next_st.cfg.stop_reserved = next_st.mode[USMIC_F_SYNC];
      end
      2'h2: begin
        next_st.cfg.stop_halves = 3'h4;
        next_st.cfg.stop_reserved = 1'b0;
      end
      default: begin
        next_st.cfg.stop_halves = 3'h2;
        next_st.cfg.stop_reserved = 1'b1;
      end
    endcase
    if (next_st.mode[USMIC_F_NINE]) begin
      next_st.cfg.char_bits = 4'h9;
    end else begin
      next_st.cfg.char_bits = 4'h5 + {2'h0, next_st.mode[USMIC_F_CHRLEN +: 2]};
    end
    next_st.cfg.bit_order = next_st.mode[USMIC_F_ORDER];
    next_st.cfg.oversample_8 = next_st.mode[USMIC_F_OVER];
    next_st.cfg.biphase_codec_enable = next_st.mode[USMIC_F_CODEC];
    next_st.cfg.biphase_start_polarity = next_st.mode[USMIC_F_STARTPOL];
    next_st.cfg.delimiter_selector = next_st.mode[USMIC_F_DELIM];
    if (next_st.mode[USMIC_F_VARSYNC]) begin
      next_st.cfg.tx_cmd_sync = next_st.tx_sync_latch;
    end else begin
      next_st.cfg.tx_cmd_sync = next_st.mode[USMIC_F_SYNC];
    end

    // interrupt follows live flags and enables
    next_st.irq = |(status_view & st.irq_mask);

    // apb answer is prepared in setup so every bus output is a flop
    next_st.pready = setup_phase;
    next_st.pslverr = setup_phase & ~is_mapped(paddr);
    if (rd_setup) begin
      if (paddr == USMIC_MODE_OFFS) begin
        next_st.prdata = st.mode;
      end else if (paddr == USMIC_IRQ_VIEW_OFFS) begin
        next_st.prdata = st.irq_mask;
      end else if (paddr == USMIC_STATUS_OFFS) begin
        next_st.prdata = status_view;
      end else begin
        next_st.prdata = 32'h0000_0000;
      end
    end else if (setup_phase) begin
      next_st.prdata = 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= USMIC_MODE_RESET;
      st.irq_mask <= USMIC_MASK_RESET;
      st.rx_sync <= 3'h7;
      st.rx_clean <= 1'b1;
      st.filt_hist <= 3'h7;
      st.txd <= 1'b1;
      st.core_rxd <= 1'b1;
      st.cfg.stop_halves <= 3'h2;
      st.cfg.char_bits <= 4'h5;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign txd_pin = st.txd;
  assign sck_pin_out = st.sck_out;
  assign sck_pin_oe = st.sck_oe;
  assign core_rxd = st.core_rxd;
  assign reject_signal = st.reject_signal;
  assign tx_char = st.tx_char;
  assign tx_char_write = st.tx_char_write;
  assign cfg = st.cfg;
  assign irq = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_enable_sets_mask: assert property (
    (wr_fire && paddr == USMIC_IRQ_ENABLE_OFFS) |=>
      ((st.irq_mask & $past(pwdata & USMIC_IRQ_VALID)) == $past(pwdata & USMIC_IRQ_VALID)))
    else $error("enable write did not set mask bits");
  a_disable_clears_mask: assert property (
    (wr_fire && paddr == USMIC_IRQ_DISABLE_OFFS) |=>
      ((st.irq_mask & $past(pwdata)) == 32'h0000_0000))
    else $error("disable write did not clear mask bits");
  a_view_reads_mask: assert property (
    (rd_setup && paddr == USMIC_IRQ_VIEW_OFFS) |=> (prdata == $past(st.irq_mask)) && pready)
    else $error("mask view read wrong");
  a_mask_unused_zero: assert property (
    (st.irq_mask & ~USMIC_IRQ_VALID) == 32'h0000_0000)
    else $error("unused mask bit set");
  a_irq_follows_flags: assert property (
    ##1 (irq == |($past(status_view) & $past(st.irq_mask))))
    else $error("interrupt output wrong");
  a_echo_drives_txd: assert property (
    (loop_mode == USMIC_LOOP_ECHO) |=> (txd_pin == $past(rx_line)))
    else $error("echo mode txd mismatch");
  a_local_loop_rx: assert property (
    (loop_mode == USMIC_LOOP_LOCAL) |=> (core_rxd == $past(core_txd)) && txd_pin)
    else $error("local loopback mismatch");
  a_remote_loop_rx: assert property (
    (loop_mode == USMIC_LOOP_REMOTE) |=> core_rxd && (txd_pin == $past(rx_line)))
    else $error("remote loopback mismatch");
  a_inhibit_no_reject: assert property (
    (char_done && st.mode[USMIC_F_INHIBIT]) |=> !reject_signal)
    else $error("reject sent while inhibited");
  a_limit_no_reject: assert property (
    limit_hit |=> !reject_signal && st.iter_flag)
    else $error("reject past limit or flag not set");
  a_iter_flag_sticky: assert property (
    (st.iter_flag && !iter_reset_now) |=> st.iter_flag)
    else $error("repeat-limit flag dropped");
  a_clock_pin_drive: assert property (
    sck_pin_oe |-> $past(st.mode[USMIC_F_CLKDRV]) &&
      ($past(st.mode[USMIC_F_CLKSEL +: 2]) != USMIC_CLKSEL_PIN))
    else $error("clock pin driven illegally");
  a_reject_each_error: assert property (
    (char_done && parity_err && !st.mode[USMIC_F_INHIBIT] &&
     !(st.mode[USMIC_F_LIMIT] && opmode == USMIC_OPMODE_T0)) |=> reject_signal)
    else $error("parity error not rejected");
  a_nine_bit_len: assert property (
    st.mode[USMIC_F_NINE] |-> (cfg.char_bits == 4'h9))
    else $error("nine-bit length not applied");
  a_bit_order_cfg: assert property (
    cfg.bit_order == st.mode[USMIC_F_ORDER])
    else $error("bit order output wrong");
  a_oversample_cfg: assert property (
    cfg.oversample_8 == st.mode[USMIC_F_OVER])
    else $error("sampling rate output wrong");
  a_biphase_cfg: assert property (
    {cfg.biphase_codec_enable, cfg.biphase_start_polarity, cfg.delimiter_selector} ==
      {st.mode[USMIC_F_CODEC], st.mode[USMIC_F_STARTPOL], st.mode[USMIC_F_DELIM]})
    else $error("biphase settings output wrong");
  a_stop_one_half: assert property (
    (st.mode[USMIC_F_STOP +: 2] == 2'h1 && !st.mode[USMIC_F_SYNC]) |-> (cfg.stop_halves == 3'h3))
    else $error("one and a half stop bits not selected");
  a_filter_hold: assert property (
    !sample_tick |=> $stable(st.filt_hist))
    else $error("filter history moved without a tick");
  a_sync_from_char: assert property (
    st.mode[USMIC_F_VARSYNC] |-> (cfg.tx_cmd_sync == st.tx_sync_latch))
    else $error("delimiter type not taken from character");
endmodule
`default_nettype wire

// ---- src/usmic_pkg.sv ----
// constants, field layout and carrier types for the serial mode and interrupt control block
`default_nettype none
package usmic_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] USMIC_CMD_OFFS = 8'h00;
  localparam logic [7:0] USMIC_MODE_OFFS = 8'h04;
  localparam logic [7:0] USMIC_IRQ_ENABLE_OFFS = 8'h08;
  localparam logic [7:0] USMIC_IRQ_DISABLE_OFFS = 8'h0C;
  localparam logic [7:0] USMIC_IRQ_VIEW_OFFS = 8'h10;
  localparam logic [7:0] USMIC_STATUS_OFFS = 8'h14;
  localparam logic [7:0] USMIC_TX_HOLD_OFFS = 8'h1C;
  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [31:0] USMIC_MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] USMIC_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] USMIC_IRQ_VALID = 32'h001F_3FFF;
  // ------------------------------------------------------------
  // mode word field positions
  // ------------------------------------------------------------
  localparam int USMIC_F_OPMODE = 0;
  localparam int USMIC_F_CLKSEL = 4;
  localparam int USMIC_F_CHRLEN = 6;
  localparam int USMIC_F_SYNC = 8;
  localparam int USMIC_F_STOP = 12;
  localparam int USMIC_F_LOOP = 14;
  localparam int USMIC_F_ORDER = 16;
  localparam int USMIC_F_NINE = 17;
  localparam int USMIC_F_CLKDRV = 18;
  localparam int USMIC_F_OVER = 19;
  localparam int USMIC_F_INHIBIT = 20;
  localparam int USMIC_F_LIMIT = 21;
  localparam int USMIC_F_VARSYNC = 22;
  localparam int USMIC_F_MAXIT = 24;
  localparam int USMIC_F_FILTER = 28;
  localparam int USMIC_F_CODEC = 29;
  localparam int USMIC_F_STARTPOL = 30;
  localparam int USMIC_F_DELIM = 31;
  // other bit positions
  localparam int USMIC_B_RST_ITER = 13;
  localparam int USMIC_B_ITER_FLAG = 10;
  localparam int USMIC_B_TX_SYNC = 15;
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [3:0] USMIC_OPMODE_T0 = 4'h4;
  localparam logic [3:0] USMIC_OPMODE_T1 = 4'h6;
  localparam logic [1:0] USMIC_CLKSEL_PIN = 2'h3;
  typedef enum logic [1:0] {
    USMIC_LOOP_NORMAL = 2'h0,
    USMIC_LOOP_ECHO = 2'h1,
    USMIC_LOOP_LOCAL = 2'h2,
    USMIC_LOOP_REMOTE = 2'h3
  } usmic_loop_t;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] stop_halves;
    logic stop_reserved;
    logic [3:0] char_bits;
    logic bit_order;
    logic oversample_8;
    logic biphase_codec_enable;
    logic biphase_start_polarity;
    logic delimiter_selector;
    logic tx_cmd_sync;
  } usmic_cfg_t;
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] irq_mask;
    logic iter_flag;
    logic [2:0] err_count;
    logic tx_sync_latch;
    logic [2:0] rx_sync;
    logic rx_clean;
    logic [2:0] filt_hist;
    logic txd;
    logic core_rxd;
    logic sck_out;
    logic sck_oe;
    logic reject_signal;
    logic irq;
    logic [8:0] tx_char;
    logic tx_char_write;
    usmic_cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } usmic_state_t;
endpackage
`default_nettype wire

// ---- verif/usmic_ctrl_bench.sv ----
// self-checking bench for the serial mode and interrupt control block
`default_nettype none
module usmic_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import usmic_pkg::*;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, status_in;
  logic rxd_pin, txd_pin, sck_pin_out, sck_pin_oe, core_txd, core_sck, sample_tick;
  logic char_done, parity_err, core_rxd, reject_signal, tx_char_write, irq;
  logic [8:0] tx_char;
  usmic_cfg_t cfg;
  int fails, samples_checked;
  logic [31:0] mode_tab [9] = '{32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_1100,
    32'h0000_20C0, 32'h0002_0040, 32'h0009_0000, 32'hE000_0000, 32'h0000_2100};
  logic [13:0] cfg_tab [9] = '{14'h1940, 14'h2140, 14'h1540, 14'h1541, 14'h2200, 14'h1240,
    14'h1170, 14'h114E, 14'h2141};
  // pins {txd, core rx} per loop mode with far end at space and core sending mark
  logic [1:0] loop_exp [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
  usmic_ctrl usmic_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .sck_pin_out(sck_pin_out), .sck_pin_oe(sck_pin_oe), .core_txd(core_txd),
    .core_sck(core_sck), .sample_tick(sample_tick), .char_done(char_done),
    .parity_err(parity_err), .status_in(status_in), .core_rxd(core_rxd),
    .reject_signal(reject_signal), .tx_char(tx_char), .tx_char_write(tx_char_write),
    .cfg(cfg), .irq(irq));
  usmic_far usmic_far_inst (.ref_clk(ref_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one apb transfer; waits for pready, a hang is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one received character; returns the reject seen in the following cycle
  task automatic char_in(input logic pe, output logic rej);
    @(posedge ref_clk);
    char_done <= 1'b1;
    parity_err <= pe;
    @(posedge ref_clk);
    char_done <= 1'b0;
    #1;
    rej = reject_signal;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #1000000;
    fails++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    logic [31:0] rd;
    logic er, rej;
    logic [3:0] rej_seq;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {core_txd, core_sck, sample_tick, char_done, parity_err} = 5'h10;
    status_in = 32'h0;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    check({txd_pin, core_rxd, sck_pin_oe, irq, reject_signal}, 32'h18);
    check(32'(cfg), 32'h1140);
    rdc(USMIC_MODE_OFFS, USMIC_MODE_RESET);
    rdc(USMIC_IRQ_VIEW_OFFS, USMIC_MASK_RESET);
    $display("test reset done");
    wr(USMIC_IRQ_ENABLE_OFFS, 32'hFFFF_FFFF);
    rdc(USMIC_IRQ_VIEW_OFFS, 32'h001F_3FFF);
    wr(USMIC_IRQ_DISABLE_OFFS, 32'h0010_0001);
    rdc(USMIC_IRQ_VIEW_OFFS, 32'h000F_3FFE);
    wr(USMIC_IRQ_ENABLE_OFFS, 32'h0);
    wr(USMIC_IRQ_DISABLE_OFFS, 32'h0);
    wr(USMIC_IRQ_VIEW_OFFS, 32'hFFFF_FFFF);
    rdc(USMIC_IRQ_VIEW_OFFS, 32'h000F_3FFE);
    rdc(USMIC_IRQ_ENABLE_OFFS, 32'h0);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    check({er, rd[30:0]}, 32'h8000_0000);
    $display("test mask registers done");
    status_in <= 32'h0010_0000;
    tick(3);
    check(irq, 1'b0);
    wr(USMIC_IRQ_ENABLE_OFFS, 32'h0010_0000);
    tick(3);
    check(irq, 1'b1);
    status_in <= 32'h0;
    tick(3);
    check(irq, 1'b0);
    status_in <= 32'h0010_0000;
    wr(USMIC_IRQ_DISABLE_OFFS, 32'h0010_0000);
    tick(3);
    check(irq, 1'b0);
    status_in <= 32'h0;
    $display("test interrupt output done");
    for (int i = 0; i < 9; i++) begin
      wr(USMIC_MODE_OFFS, mode_tab[i]);
      tick(2);
      check(32'(cfg), {18'h0, cfg_tab[i]});
      rdc(USMIC_MODE_OFFS, mode_tab[i]);
    end
    $display("test frame format done");
    // far end sends space while the core transmits mark: each mode differs
    usmic_far_inst.drive(1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(USMIC_MODE_OFFS, 32'(m) << USMIC_F_LOOP);
      tick(8);
      check({txd_pin, core_rxd}, loop_exp[m]);
      check(usmic_far_inst.heard[3:0], {4{loop_exp[m][1]}});
    end
    // local loop must carry the transmitter, not a constant
    wr(USMIC_MODE_OFFS, 32'h0000_8000);
    core_txd <= 1'b0;
    tick(3);
    check({txd_pin, core_rxd}, 2'h2);
    core_txd <= 1'b1;
    usmic_far_inst.drive(1'b1);
    $display("test channel loop done");
    // filter: without ticks the line change must not pass
    wr(USMIC_MODE_OFFS, 32'h1000_4000);
    usmic_far_inst.drive(1'b0);
    tick(8);
    check(txd_pin, 1'b1);
    repeat (2) begin
      @(posedge ref_clk);
      sample_tick <= 1'b1;
      @(posedge ref_clk);
      sample_tick <= 1'b0;
    end
    tick(6);
    check(txd_pin, 1'b0);
    usmic_far_inst.drive(1'b1);
    $display("test receive filter done");
    core_sck <= 1'b1;
    wr(USMIC_MODE_OFFS, 32'h0004_0000);
    tick(2);
    check({sck_pin_oe, sck_pin_out}, 2'h3);
    wr(USMIC_MODE_OFFS, 32'h0004_0030);
    tick(2);
    check(sck_pin_oe, 1'b0);
    wr(USMIC_MODE_OFFS, 32'h0);
    tick(2);
    check(sck_pin_oe, 1'b0);
    $display("test clock pin done");
    char_in(1'b1, rej);
    check(rej, 1'b1);
    char_in(1'b0, rej);
    check(rej, 1'b0);
    wr(USMIC_MODE_OFFS, 32'h0010_0000);
    char_in(1'b1, rej);
    check(rej, 1'b0);
    wr(USMIC_MODE_OFFS, 32'h0220_0004);
    for (int k = 0; k < 3; k++) begin
      char_in(1'b1, rej_seq[k]);
    end
    check(rej_seq[2:0], 3'h3);
    rdc(USMIC_STATUS_OFFS, 32'h0000_0400);
    char_in(1'b0, rej);
    rdc(USMIC_STATUS_OFFS, 32'h0000_0400);
    wr(USMIC_CMD_OFFS, 32'h0000_2000);
    rdc(USMIC_STATUS_OFFS, 32'h0);
    char_in(1'b1, rej);
    check(rej, 1'b1);
    wr(USMIC_MODE_OFFS, 32'h0220_0006);
    for (int k = 0; k < 4; k++) begin
      char_in(1'b1, rej_seq[k]);
    end
    check(rej_seq, 4'hF);
    $display("test reject handling done");
    wr(USMIC_MODE_OFFS, 32'h0040_0000);
    wr(USMIC_TX_HOLD_OFFS, 32'h0000_81A5);
    tick(0);
    check(tx_char_write, 1'b1);
    tick(2);
    check({cfg.tx_cmd_sync, tx_char}, 32'h3A5);
    check(tx_char_write, 1'b0);
    wr(USMIC_TX_HOLD_OFFS, 32'h0000_0003);
    tick(2);
    check({cfg.tx_cmd_sync, tx_char}, 32'h003);
    $display("test delimiter type done");
    conclude();
  end
endmodule
`default_nettype wire

// ---- verif/usmic_far.sv ----
// remote transceiver model standing on the serial line of the mode control block
`default_nettype none
module usmic_far (
  // clock
  input wire logic ref_clk,
  // serial line
  input wire logic txd_pin,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] heard;
  // ------------------------------------------------------------
  // line driver
  // ------------------------------------------------------------
  // idle mark level until told otherwise
  initial begin
    rxd_pin = 1'b1;
  end
  task automatic drive(input logic v);
    @(posedge ref_clk);
    rxd_pin <= v;
  endtask
  // ------------------------------------------------------------
  // listener
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    heard <= {heard[6:0], txd_pin};
  end
endmodule
`default_nettype wire
